// file: src/clg_map.svh
// Register offsets, field positions and selector reset value of the gate 1 term selector
`ifndef CLG_MAP_SVH
`define CLG_MAP_SVH

`define CLG_SEL_OFS        32'h0000_0000
`define CLG_STAT_OFS       32'h0000_0004
`define CLG_SEL_RST        8'h00
`define CLG_SEL_WIDTH      8
`define CLG_DATA_WIDTH     4
`define CLG_STAT_DATA_LSB  0
`define CLG_STAT_GATE_BIT  4
`define CLG_STAT_TERM_LSB  8
`define CLG_ZERO_WORD      32'h0000_0000
`define CLG_MIN_ADDR_WIDTH 3
`define CLG_MAX_ADDR_WIDTH 31

`endif

// file: src/clg_pkg.sv
// Types shared by the gate 1 term selector modules
package clg_pkg;

   typedef enum logic [1:0] {
      CLG_IDLE   = 2'b01,
      CLG_ACCESS = 2'b10
   } clg_apb_state_t;

   typedef logic [7:0] clg_sel_t;
   typedef logic [3:0] clg_data_t;

endpackage : clg_pkg

// file: src/clg_gate_if.sv
// Carrier between the register side and the gate 1 term combiner
`timescale 1ns/100ps
interface clg_gate_if;
   logic [3:0] data;
   logic [7:0] enable;
   logic [7:0] terms;
   logic       gate;

   modport src  (output data, output enable, input  terms, input  gate);
   modport comb (input  data, input  enable, output terms, output gate);
endinterface : clg_gate_if

// file: src/clg_sync.sv
// Two-flop synchroniser for a bus of independent level inputs
`timescale 1ns/100ps
module clg_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage_one;

   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("clg_sync: WIDTH must be at least 1");
      end
   endgenerate

   // Only the second stage reads the first
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stage_one <= '0;
         sync_out  <= '0;
      end else begin
         stage_one <= async_in;
         sync_out  <= stage_one;
      end
   end
endmodule : clg_sync

// file: src/clg_gate_comb.sv
// Term builder and OR combiner for gate 1
`timescale 1ns/100ps
module clg_gate_comb (
   // Terms and enables
   clg_gate_if.comb gif
);
   logic first_input_true;
   logic first_input_inverted;
   logic second_input_true;
   logic second_input_inverted;
   logic third_input_true;
   logic third_input_inverted;
   logic fourth_input_true;
   logic fourth_input_inverted;
   logic [7:0] raw_terms;

   always_comb begin
      first_input_true      = gif.data[0];
      first_input_inverted  = ~gif.data[0];
      second_input_true     = gif.data[1];
      second_input_inverted = ~gif.data[1];
      third_input_true      = gif.data[2];
      third_input_inverted  = ~gif.data[2];
      fourth_input_true     = gif.data[3];
      fourth_input_inverted = ~gif.data[3];
      // Even bits carry the inverted form, odd bits the true form
      raw_terms = {fourth_input_true, fourth_input_inverted,
                   third_input_true,  third_input_inverted,
                   second_input_true, second_input_inverted,
                   first_input_true,  first_input_inverted};
   end

   always_comb begin
      gif.terms[7] = raw_terms[7] & gif.enable[7]; // [RL7]
      gif.terms[6] = raw_terms[6] & gif.enable[6]; // [RL1]
      gif.terms[5] = raw_terms[5] & gif.enable[5]; // [RL2]
      gif.terms[4] = raw_terms[4] & gif.enable[4]; // [RL3]
      gif.terms[3] = raw_terms[3] & gif.enable[3]; // [RL4]
      gif.terms[2] = raw_terms[2] & gif.enable[2]; // [RL5]
      gif.terms[1] = raw_terms[1] & gif.enable[1]; // [RL6]
      gif.terms[0] = raw_terms[0] & gif.enable[0]; // [RL7]
      // No term enabled leaves the gate low
      gif.gate = |gif.terms;
   end
endmodule : clg_gate_comb

// file: src/clg_gate1_select.sv
// Gate 1 input-term selector with its APB register slave
//
// The implementer's own choices: the APB slave port and the address map.
`include "clg_map.svh"
`timescale 1ns/100ps

// Functional notes
// RL1: Bit 6 gates inverted fourth input
// RL2: Bit 5 gates true third input
// RL3: Bit 4 gates inverted third input
// RL4: Bit 3 gates true second input
// RL5: Bit 2 gates inverted second input
// RL6: Bit 1 gates true first input
// RL7: Bit 7 true fourth, bit 0 inverted first
module clg_gate1_select
   import clg_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_WIDTH-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Selected data inputs from the cell multiplexers
   input  wire logic [3:0]            sel_data,
   // Gate 1 result
   output logic                       gate_one_output
);
   clg_apb_state_t state;
   clg_sel_t       gate1_input_select;
   clg_data_t      data_synced;
   logic [31:0]    full_addr;
   logic           hit_sel;
   logic           hit_stat;
   logic           setup_phase;
   logic           do_write;
   logic [31:0]    next_prdata;
   logic           next_pslverr;

   clg_gate_if gif ();

   generate
      if (ADDR_WIDTH < `CLG_MIN_ADDR_WIDTH || ADDR_WIDTH > `CLG_MAX_ADDR_WIDTH) begin : g_bad
         $error("clg_gate1_select: ADDR_WIDTH out of range");
      end
   endgenerate

   // Selected inputs may come straight from pins, so they are synchronised
   clg_sync #(
      .WIDTH (`CLG_DATA_WIDTH)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (sel_data),
      .sync_out (data_synced)
   );

   assign gif.data   = data_synced;
   assign gif.enable = gate1_input_select;

   clg_gate_comb u_comb (
      .gif (gif)
   );

   // Address decode
   always_comb begin
      full_addr    = {{(32-ADDR_WIDTH){1'b0}}, paddr};
      hit_sel      = (full_addr == `CLG_SEL_OFS);
      hit_stat     = (full_addr == `CLG_STAT_OFS);
      setup_phase  = psel && !penable && (state == CLG_IDLE);
      do_write     = (state == CLG_ACCESS) && psel && penable && pready && pwrite;
   end

   // Read data and error are fixed in the setup cycle so every output is a flop
   always_comb begin
      next_prdata  = `CLG_ZERO_WORD;
      next_pslverr = 1'b0;
      if (hit_sel) begin
         next_prdata[`CLG_SEL_WIDTH-1:0] = gate1_input_select;
      end else if (hit_stat) begin
         next_prdata[`CLG_STAT_DATA_LSB +: `CLG_DATA_WIDTH] = data_synced;
         next_prdata[`CLG_STAT_GATE_BIT]                    = gate_one_output;
         next_prdata[`CLG_STAT_TERM_LSB +: `CLG_SEL_WIDTH]  = gif.terms;
         next_pslverr = pwrite;
      end else begin
         next_pslverr = 1'b1;
      end
   end

   // One wait-free access phase per transfer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state <= CLG_IDLE;
      end else begin
         case (state)
            CLG_IDLE: begin
               if (setup_phase) begin
                  state <= CLG_ACCESS;
               end
            end
            CLG_ACCESS: begin
               state <= CLG_IDLE;
            end
            default: begin
               state <= CLG_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `CLG_ZERO_WORD;
      end else if (setup_phase) begin
         pready  <= 1'b1;
         pslverr <= next_pslverr;
         prdata  <= pwrite ? `CLG_ZERO_WORD : next_prdata;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `CLG_ZERO_WORD;
      end
   end

   // Only byte lane 0 holds the selector; other lanes are ignored
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gate1_input_select <= `CLG_SEL_RST;
      end else if (do_write && hit_sel && pstrb[0]) begin
         gate1_input_select <= pwdata[`CLG_SEL_WIDTH-1:0]; // [RL1] [RL2] [RL3] [RL4] [RL5] [RL6] [RL7]
      end
   end

   // Registered so the output never glitches while terms change
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gate_one_output <= 1'b0;
      end else begin
         gate_one_output <= gif.gate; // [RL1] [RL6] [RL7]
      end
   end
endmodule : clg_gate1_select

// file: verification/clg_gate1_select_monitor.sv
// Port-level checks of the gate 1 term selector
`timescale 1ns/100ps
module clg_gate1_select_monitor
   import clg_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   // Clock and reset
   input wire logic                  clk_sys,
   input wire logic                  rst_n,
   // APB
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [3:0]            pstrb,
   input wire logic                  pready,
   // Data and result
   input wire logic [3:0]            sel_data,
   input wire logic                  gate_one_output
);
   clg_sel_t   mir;
   clg_data_t  d_q;
   logic [2:0] quiet;
   logic [7:0] tm;
   logic       wr;
   assign wr = psel && penable && pready && pwrite && paddr == '0 && pstrb[0];
   // Delayed data, since the gate lags the pins by the synchroniser
   assign tm = mir & {d_q[3], ~d_q[3], d_q[2], ~d_q[2], d_q[1], ~d_q[1], d_q[0], ~d_q[0]};
   always_ff @(posedge clk_sys) begin
      if (!rst_n) mir <= 8'h00;
      else if (wr) mir <= pwdata[7:0];
   end
   always_ff @(posedge clk_sys) begin
      d_q <= sel_data;
      if (!rst_n || wr || sel_data != d_q) quiet <= 3'h0;
      else if (quiet != 3'h4) quiet <= quiet + 3'h1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_d4n; quiet == 3'h4 && tm[6] |-> gate_one_output; endproperty
   a_d4n: assert property (p_d4n) else $error("inverted d4 term lost");
   property p_d3t; quiet == 3'h4 && tm[5] |-> gate_one_output; endproperty
   a_d3t: assert property (p_d3t) else $error("true d3 term lost");
   property p_d3n; quiet == 3'h4 && tm[4] |-> gate_one_output; endproperty
   a_d3n: assert property (p_d3n) else $error("inverted d3 term lost");
   property p_d2t; quiet == 3'h4 && tm[3] |-> gate_one_output; endproperty
   a_d2t: assert property (p_d2t) else $error("true d2 term lost");
   property p_d2n; quiet == 3'h4 && tm[2] |-> gate_one_output; endproperty
   a_d2n: assert property (p_d2n) else $error("inverted d2 term lost");
   property p_d1t; quiet == 3'h4 && tm[1] |-> gate_one_output; endproperty
   a_d1t: assert property (p_d1t) else $error("true d1 term lost");
   property p_ends; quiet == 3'h4 && (tm[7] || tm[0]) |-> gate_one_output; endproperty
   a_ends: assert property (p_ends) else $error("end term lost");
   property p_none; quiet == 3'h4 && tm == 8'h00 |-> !gate_one_output; endproperty
   a_none: assert property (p_none) else $error("excluded term seen");
   property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready not a single pulse");
endmodule : clg_gate1_select_monitor

bind clg_gate1_select clg_gate1_select_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .sel_data(sel_data),
   .gate_one_output(gate_one_output));

// file: verification/tb_clg_gate1_select.sv
// Self-checking bench of the gate 1 term selector
`timescale 1ns/100ps
module tb_clg_gate1_select;
   import clg_pkg::*;
   logic        clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0]  pstrb = 4'hf;
   clg_data_t   sel_data = 4'h0;
   logic        pready, pslverr, gate_one_output, er, g;
   int          errors = 0, checks = 0, cyc = 0;
   always #2 clk_sys = ~clk_sys;
   clg_gate1_select u_clg_gate1_select (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sel_data(sel_data),
      .gate_one_output(gate_one_output));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Holding psel through keep gives a back-to-back setup
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input bit keep = 0);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // This wait ends when pready goes high, or at the bench timeout if it never does
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      penable <= 1'b0;
      if (!keep) begin
         psel <= 1'b0;
         @(posedge clk_sys);
      end
   endtask : apb
   task automatic t_terms;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 12'h000, 32'h1 << i);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd, 32'h1 << i);
         for (int v = 0; v < 16; v++) begin
            sel_data <= 4'(v);
            repeat (5) @(posedge clk_sys);
            g = i[0] ? v[i >> 1] : !v[i >> 1];
            chk({31'h0, gate_one_output}, {31'h0, g});
            apb(1'b0, 12'h004, 32'h0);
            chk(rd & 32'hff1f, {16'h0, g ? 8'(1 << i) : 8'h00, 3'h0, g, 4'(v)});
         end
      end
   endtask : t_terms
   task automatic t_refuse;
      apb(1'b1, 12'h000, 32'h0000_005a, 1'b1);
      apb(1'b1, 12'h008, 32'h0000_00ff, 1'b1);
      chk({31'h0, er}, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, 12'h004, 32'h0000_00ff);
      chk({31'h0, er}, 32'h1);
      pstrb <= 4'h0;
      apb(1'b1, 12'h000, 32'h0000_00ff);
      pstrb <= 4'hf;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0000_005a);
   endtask : t_refuse
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      t_terms();
      t_refuse();
      tally_and_finish();
   end
endmodule : tb_clg_gate1_select
